// File: core/dimm_map_consts.vh
/*
 * Constants for the DIMM address map and throttle block: configuration
 * codes, translation table columns and throttle control field positions.
 * Assumes it is included by its bare name from the design files.
 */
// Behaviour
// - Column phase: host bit 3 on A0, bits 5 upward on A1 onward, precharge on A10.
// - At most four chip-select rows; each DIMM side is one row.
// - Accept 64-bit DIMMs of x8 or x16 devices, 128, 256 or 512 Mb.
// - Only standard arrangements; double-sided x16 DIMMs are flagged unsupported.
// - No own size or type detection; configuration comes from outside.
// - No error-correction support even when the DIMM reports check bits.
// - Above the thermal threshold, reads and writes to DRAM are cut back.
// - Read and write throttles are independent, each with a 64-bit control word.
// - Throttling starts on the force bit or on counter threshold crossing.
`ifndef DIMM_MAP_CONSTS_VH
`define DIMM_MAP_CONSTS_VH

`define ROWS 4
`define ROW_SEL_W 2
`define HOST_ADDR_W 32
`define MEM_ADDR_W 13
`define AP_LINE 10

// Configuration codes, one per supported technology and width.
`define CFG_W 3
`define CFG_128_X16 3'h0
`define CFG_128_X8 3'h1
`define CFG_256_X16 3'h2
`define CFG_256_X8 3'h3
`define CFG_512_X16 3'h4
`define CFG_512_X8 3'h5

// Presence address upper nibble.
`define PRESENCE_HI 4'ha

// Throttle control word layout (64 bits).
`define THR_W 64
`define THR_FORCE_BIT 0
`define THR_ENABLE_BIT 1
`define THR_LIMIT_LO 8
`define THR_LIMIT_HI 23
`define THR_WINDOW_LO 32
`define THR_WINDOW_HI 47
`define THR_DUTY_LO 48
`define THR_DUTY_HI 55
`define CNT_W 16
`define DUTY_W 8

`endif

// File: core/throttle_unit.v
/*
 * One throttle channel: counts accesses per window, and when forced or
 * over the limit it blocks issue for part of each duty period.
 * Assumes the control word is held stable by its owner.
 */
`timescale 1ns/100ps
`include "dimm_map_consts.vh"

module throttle_unit (
    input wire clock_i,
    input wire reset_n_i,
    input wire [`THR_W-1:0] control_i,
    input wire access_i,
    output wire block_o,
    output wire active_o
);
    reg [`CNT_W-1:0] window_reg;
    reg [`CNT_W-1:0] count_reg;
    reg over_reg;
    reg [`DUTY_W-1:0] phase_reg;
    wire [`CNT_W-1:0] limit = control_i[`THR_LIMIT_HI:`THR_LIMIT_LO];
    wire [`CNT_W-1:0] window = control_i[`THR_WINDOW_HI:`THR_WINDOW_LO];
    wire [`DUTY_W-1:0] duty = control_i[`THR_DUTY_HI:`THR_DUTY_LO];
    wire enable = control_i[`THR_ENABLE_BIT];
    wire force_throttle_bit = control_i[`THR_FORCE_BIT];
    wire window_end = (window_reg == window);

    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            window_reg <= {`CNT_W{1'b0}};
            count_reg <= {`CNT_W{1'b0}};
            over_reg <= 1'b0;
            phase_reg <= {`DUTY_W{1'b0}};
        end else begin
            phase_reg <= phase_reg + 8'h01;
            if (window_end) begin
                window_reg <= {`CNT_W{1'b0}};
                count_reg <= {`CNT_W{1'b0}};
                over_reg <= enable && (count_reg > limit);
            end else begin
                window_reg <= window_reg + 16'h0001;
                if (access_i && count_reg != {`CNT_W{1'b1}})
                    count_reg <= count_reg + 16'h0001;
            end
        end
    end

    assign active_o = force_throttle_bit | over_reg;
    assign block_o = active_o && (phase_reg < duty);
endmodule

// File: core/dimm_map.v
/*
 * DIMM address map and throttle: translates host addresses to row,
 * column and bank lines for dual-channel internal-graphics dynamic mode,
 * checks the row configuration and gates issue through two throttles.
 * Assumes configuration inputs are set by firmware from presence data
 * before memory requests start, and are quasi-static.
 */
`timescale 1ns/100ps
`include "dimm_map_consts.vh"

module dimm_map (
    input wire clock_i,
    input wire reset_n_i,
    input wire [`ROWS*`CFG_W-1:0] row_cfg_i,
    input wire [`ROWS-1:0] row_populated_i,
    input wire [`ROWS-1:0] row_double_i,
    input wire [`ROWS-1:0] row_ecc_i,
    input wire config_done_i,
    input wire [2:0] presence_addr_straps_i,
    input wire [`THR_W-1:0] read_throttle_i,
    input wire [`THR_W-1:0] write_throttle_i,
    input wire req_valid_i,
    input wire req_write_i,
    input wire req_precharge_i,
    input wire [`HOST_ADDR_W-1:0] req_addr_i,
    input wire [`ROW_SEL_W-1:0] req_row_i,
    output reg req_ready_o,
    output reg map_valid_o,
    output reg map_write_o,
    output reg [`ROWS-1:0] chip_select_o,
    output reg [`MEM_ADDR_W-1:0] row_addr_o,
    output reg [`MEM_ADDR_W-1:0] col_addr_o,
    output reg bank_line_hi_o,
    output reg bank_line_lo_o,
    output reg [`ROWS-1:0] row_unsupported_o,
    output reg [6:0] presence_addr_o,
    output reg read_throttle_o,
    output reg write_throttle_o
);
    reg [`ROWS-1:0] row_bad_next;
    reg [`CFG_W-1:0] cfg;
    reg [`MEM_ADDR_W-1:0] row_next;
    reg [`MEM_ADDR_W-1:0] col_next;
    reg hi_next;
    reg lo_next;
    wire rd_block;
    wire wr_block;
    wire rd_active;
    wire wr_active;
    wire [`HOST_ADDR_W-1:0] a = req_addr_i;
    integer i;

    // Per-row check of the externally supplied configuration.
    always @* begin
        row_bad_next = {`ROWS{1'b0}};
        for (i = 0; i < `ROWS; i = i + 1) begin
            if (row_populated_i[i]) begin
                if (row_cfg_i[i*`CFG_W +: `CFG_W] > `CFG_512_X8)
                    row_bad_next[i] = 1'b1;
                if (row_double_i[i] && !row_cfg_i[i*`CFG_W])
                    row_bad_next[i] = 1'b1;
            end
        end
    end

    // Translation per configuration; unused lines drive zero.
    always @* begin
        cfg = row_cfg_i[req_row_i*`CFG_W +: `CFG_W];
        row_next = {`MEM_ADDR_W{1'b0}};
        hi_next = 1'b0;
        lo_next = 1'b0;
        row_next[0] = a[17];
        row_next[4] = a[21];
        row_next[5] = a[22];
        row_next[6] = a[23];
        row_next[11] = a[16];
        case (cfg)
            `CFG_128_X16: begin
                hi_next = a[18];
                lo_next = a[13];
                row_next[1] = a[15];
                row_next[2] = a[24];
                row_next[3] = a[25];
                row_next[7] = a[27];
                row_next[8] = a[28];
                row_next[9] = a[26];
                row_next[10] = a[14];
            end
            `CFG_128_X8: begin
                hi_next = a[14];
                lo_next = a[18];
                row_next[1] = a[15];
                row_next[2] = a[28];
                row_next[3] = a[29];
                row_next[7] = a[24];
                row_next[8] = a[25];
                row_next[9] = a[26];
                row_next[10] = a[27];
            end
            `CFG_256_X16: begin
                hi_next = a[18];
                lo_next = a[13];
                row_next[1] = a[15];
                row_next[2] = a[28];
                row_next[3] = a[29];
                row_next[7] = a[24];
                row_next[8] = a[25];
                row_next[9] = a[26];
                row_next[10] = a[14];
                row_next[12] = a[27];
            end
            `CFG_256_X8, `CFG_512_X16: begin
                hi_next = a[14];
                lo_next = a[18];
                row_next[1] = a[15];
                row_next[2] = a[29];
                row_next[3] = a[30];
                row_next[7] = a[24];
                row_next[8] = a[25];
                row_next[9] = a[26];
                row_next[10] = a[27];
                row_next[12] = a[28];
            end
            `CFG_512_X8: begin
                hi_next = a[18];
                lo_next = a[15];
                row_next[1] = a[16];
                row_next[2] = a[24];
                row_next[3] = a[25];
                row_next[7] = a[30];
                row_next[8] = a[31];
                row_next[9] = a[26];
                row_next[10] = a[27];
                row_next[11] = a[29];
                row_next[12] = a[28];
            end
            default: begin
                row_next = {`MEM_ADDR_W{1'b0}};
            end
        endcase
        // Column phase: bit 3 on A0, bits 5..12 on A1..A8, bit 13 on A9 except 128/256 x16, bit 14 on A11 for 512 x8, precharge on A10.
        col_next = {`MEM_ADDR_W{1'b0}};
        col_next[0] = a[3];
        col_next[1] = a[5];
        col_next[2] = a[6];
        col_next[3] = a[7];
        col_next[4] = a[8];
        col_next[5] = a[9];
        col_next[6] = a[10];
        col_next[7] = a[11];
        col_next[8] = a[12];
        if (cfg == `CFG_128_X8 || cfg == `CFG_256_X8 || cfg == `CFG_512_X16 ||
            cfg == `CFG_512_X8)
            col_next[9] = a[13];
        if (cfg == `CFG_512_X8)
            col_next[11] = a[14];
        col_next[`AP_LINE] = req_precharge_i;
    end

    throttle_unit read_thr (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .control_i(read_throttle_i),
        .access_i(map_valid_o && !map_write_o),
        .block_o(rd_block),
        .active_o(rd_active)
    );

    throttle_unit write_thr (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .control_i(write_throttle_i),
        .access_i(map_valid_o && map_write_o),
        .block_o(wr_block),
        .active_o(wr_active)
    );

    wire row_ok = row_populated_i[req_row_i] && !row_bad_next[req_row_i];
    // Reads and writes are held back separately while their throttle blocks.
    wire issue_ok = config_done_i && row_ok && (req_write_i ? !wr_block : !rd_block);

    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            req_ready_o <= 1'b0;
            map_valid_o <= 1'b0;
            map_write_o <= 1'b0;
            chip_select_o <= {`ROWS{1'b0}};
            row_addr_o <= {`MEM_ADDR_W{1'b0}};
            col_addr_o <= {`MEM_ADDR_W{1'b0}};
            bank_line_hi_o <= 1'b0;
            bank_line_lo_o <= 1'b0;
            row_unsupported_o <= {`ROWS{1'b0}};
            presence_addr_o <= 7'h00;
            read_throttle_o <= 1'b0;
            write_throttle_o <= 1'b0;
        end else begin
            req_ready_o <= issue_ok;
            map_valid_o <= req_valid_i && issue_ok;
            map_write_o <= req_write_i;
            // Error-correction capability of a DIMM is ignored on purpose.
            chip_select_o <= (req_valid_i && issue_ok) ?
                (4'h1 << req_row_i) : {`ROWS{1'b0}};
            row_addr_o <= row_next;
            col_addr_o <= col_next;
            bank_line_hi_o <= hi_next;
            bank_line_lo_o <= lo_next;
            row_unsupported_o <= row_bad_next;
            presence_addr_o <= {`PRESENCE_HI, presence_addr_straps_i};
            read_throttle_o <= rd_active;
            write_throttle_o <= wr_active;
        end
    end
endmodule

// File: sim/dimm_map_chk.sv
/* Port assertions for dimm_map. Assumes one clock, sync active-low reset. */
`timescale 1ns/100ps
module dimm_map_chk (
    input wire clock_i, reset_n_i, config_done_i, req_valid_i, req_precharge_i,
    input wire map_valid_o, read_throttle_o,
    input wire [11:0] row_cfg_i,
    input wire [3:0] row_populated_i, row_double_i, chip_select_o,
    input wire [2:0] presence_addr_straps_i,
    input wire [63:0] read_throttle_i,
    input wire [31:0] req_addr_i,
    input wire [1:0] req_row_i,
    input wire [12:0] col_addr_o,
    input wire [6:0] presence_addr_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    chk_config_gate:
        assert property (!config_done_i |=> !map_valid_o) else $error("early issue");
    chk_col_low:
        assert property (map_valid_o |-> col_addr_o[0] == $past(req_addr_i[3])
            && col_addr_o[1] == $past(req_addr_i[5])) else $error("column bits");
    chk_col_precharge:
        assert property (map_valid_o |-> col_addr_o[10] == $past(req_precharge_i))
            else $error("precharge flag");
    chk_cs_row:
        assert property (map_valid_o |-> chip_select_o == 4'h1 << $past(req_row_i))
            else $error("chip select");
    chk_cs_idle:
        assert property (!map_valid_o |-> chip_select_o == 4'h0) else $error("stray select");
    chk_row_absent:
        assert property (req_valid_i && !row_populated_i[req_row_i] |=> !map_valid_o)
            else $error("absent row issued");
    chk_x16_double:
        assert property (req_valid_i && row_double_i[req_row_i]
            && !row_cfg_i[3 * req_row_i] |=> !map_valid_o) else $error("x16 double issued");
    chk_presence_addr:
        assert property ($past(reset_n_i) |-> presence_addr_o
            == {4'ha, $past(presence_addr_straps_i)}) else $error("presence address");
    chk_force_read:
        assert property (read_throttle_i[0] |=> read_throttle_o) else $error("force ignored");
    cov_issue: cover property (map_valid_o && col_addr_o[10]);
    cov_read_thr: cover property (read_throttle_o);
    cov_refused: cover property (req_valid_i && !config_done_i);
endmodule
bind dimm_map dimm_map_chk i_chk (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .config_done_i(config_done_i), .req_valid_i(req_valid_i),
    .req_precharge_i(req_precharge_i), .map_valid_o(map_valid_o),
    .read_throttle_o(read_throttle_o), .row_cfg_i(row_cfg_i),
    .row_populated_i(row_populated_i), .row_double_i(row_double_i),
    .chip_select_o(chip_select_o), .presence_addr_straps_i(presence_addr_straps_i),
    .read_throttle_i(read_throttle_i), .req_addr_i(req_addr_i), .req_row_i(req_row_i),
    .col_addr_o(col_addr_o), .presence_addr_o(presence_addr_o));

// File: sim/dimm_model.sv
/* DIMM with strap pins and presence ROM. Assumes the bench reads the ROM. */
`timescale 1ns/100ps
module dimm_model (
    input wire [7:0] byte_sel_i,
    output wire [2:0] straps_o,
    output reg [7:0] byte_o
);
    assign straps_o = 3'h5;
    always @* begin
        case (byte_sel_i)
            8'h03: byte_o = 8'h0d;
            8'h04: byte_o = 8'h0a;
            8'h05: byte_o = 8'h02;
            8'h0b: byte_o = 8'h02;
            default: byte_o = 8'h00;
        endcase
    end
endmodule

// File: sim/tb.sv
/* Bench for dimm_map with a DIMM model. Assumes the checker binds itself. */
`timescale 1ns/100ps
module tb;
    reg clock_i = 0, reset_n_i = 0, config_done_i = 0, p_v = 0, p_w, p_ap, seen_wr = 0;
    reg req_valid_i = 0, req_write_i = 0, req_precharge_i = 0;
    reg [11:0] row_cfg_i = 0;
    reg [3:0] row_populated_i = 0, row_double_i = 0, row_ecc_i = 0;
    reg [63:0] read_throttle_i = 0, write_throttle_i = 0;
    reg [31:0] req_addr_i = 0, p_a;
    reg [1:0] req_row_i = 0, p_row;
    reg [7:0] rom_sel = 0, nr;
    reg [2:0] p_cfg;
    wire [7:0] rom_byte;
    wire [2:0] straps;
    wire rdy, map_valid_o, map_write_o, bank_line_hi_o, bank_line_lo_o, rd_thr, wr_thr;
    wire [3:0] chip_select_o, row_unsupported_o;
    wire [12:0] row_addr_o, col_addr_o;
    wire [6:0] presence_addr_o;
    integer seed = 9, failures = 0, samples_checked = 0, hits = 0, k;
    always #5 clock_i = ~clock_i;
    dimm_model i_dimm (.byte_sel_i(rom_sel), .straps_o(straps), .byte_o(rom_byte));
    dimm_map i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .row_cfg_i(row_cfg_i),
        .row_populated_i(row_populated_i), .row_double_i(row_double_i),
        .row_ecc_i(row_ecc_i), .config_done_i(config_done_i),
        .presence_addr_straps_i(straps), .read_throttle_i(read_throttle_i),
        .write_throttle_i(write_throttle_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_precharge_i(req_precharge_i),
        .req_addr_i(req_addr_i), .req_row_i(req_row_i), .req_ready_o(rdy),
        .map_valid_o(map_valid_o), .map_write_o(map_write_o),
        .chip_select_o(chip_select_o), .row_addr_o(row_addr_o), .col_addr_o(col_addr_o),
        .bank_line_hi_o(bank_line_hi_o), .bank_line_lo_o(bank_line_lo_o),
        .row_unsupported_o(row_unsupported_o), .presence_addr_o(presence_addr_o),
        .read_throttle_o(rd_thr), .write_throttle_o(wr_thr));
    task check(input [63:0] seen, input [63:0] exp, input string what);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    function [12:0] col_mask(input [2:0] c);
        col_mask = c == 3'h5 ? 13'h0fff : (c[0] || c == 3'h4) ? 13'h07ff : 13'h05ff;
    endfunction
    function [3:0] bank_exp(input [2:0] c, input [31:0] a);
        bank_exp = {(c[0] && c != 3'h5 || c == 3'h4) ? a[14] : a[18],
            c == 3'h5 ? a[15] : (c[0] || c == 3'h4) ? a[18] : a[13],
            c == 3'h5 ? a[16] : a[15], a[17]};
    endfunction
    function [12:0] row_exp(input [2:0] c, input [31:0] a);
        case (c)
            3'h0: row_exp = {1'b0, a[16], a[14], a[26], a[28], a[27], a[23:21], a[25:24],
                a[15], a[17]};
            3'h1: row_exp = {1'b0, a[16], a[27:21], a[29:28], a[15], a[17]};
            3'h2: row_exp = {a[27], a[16], a[14], a[26:21], a[29:28], a[15], a[17]};
            3'h3, 3'h4: row_exp = {a[28], a[16], a[27:21], a[30:29], a[15], a[17]};
            3'h5: row_exp = {a[28], a[29], a[27], a[26], a[31:30], a[23:21], a[25:24],
                a[16], a[17]};
            default: row_exp = 13'h0000;
        endcase
    endfunction
    task step(input [1:0] thr, input [2:0] c1);
        reg ok;
        reg rd;
        reg [12:0] m;
        begin
            @(negedge clock_i);
            rd = config_done_i && row_populated_i[p_row] && p_cfg < 3'h6
                && !(row_double_i[p_row] && !p_cfg[0]);
            ok = p_v && rd;
            seen_wr = seen_wr | wr_thr;
            m = col_mask(p_cfg);
            if (thr[p_w]) hits = hits + map_valid_o;
            else begin
                check(map_valid_o, ok, "map_valid");
                check(rdy, rd, "req_ready");
                if (ok) begin
                    check(row_addr_o, row_exp(p_cfg, p_a), "row");
                    check(chip_select_o, 4'h1 << p_row, "chip_select");
                    check(col_addr_o & m, {1'b0, p_a[14], p_ap, p_a[13:5], p_a[3]} & m, "col");
                    check({bank_line_hi_o, bank_line_lo_o, row_addr_o[1:0]}, bank_exp(p_cfg, p_a), "bank");
                    check(map_write_o, p_w, "map_write");
                end
            end
            check(presence_addr_o, {4'ha, straps}, "presence");
            row_cfg_i[5:3] = c1;
            {p_v, p_w, p_ap, p_row} = 5'($random(seed));
            p_a = $random(seed);
            p_cfg = row_cfg_i[3 * p_row +: 3];
            req_valid_i = p_v;
            req_write_i = p_w;
            req_precharge_i = p_ap;
            req_addr_i = p_a;
            req_row_i = p_row;
        end
    endtask
    initial begin
        rom_sel = 8'h03;
        #1 nr = rom_byte;
        rom_sel = 8'h04;
        #1 row_cfg_i = {6'o22, {2{1'b0, nr[0], ~rom_byte[0]}}};
        rom_sel = 8'h05;
        #1 row_double_i = {2'b01, {2{rom_byte == 8'h02}}};
        rom_sel = 8'h0b;
        #1 row_ecc_i = {4{rom_byte != 8'h00}};
        row_populated_i = 4'h7;
        repeat (4) @(negedge clock_i);
        reset_n_i = 1;
        check(map_valid_o, 0, "reset_valid");
        for (k = 0; k < 30; k = k + 1) step(2'b00, 3'h3);
        config_done_i = 1;
        check(row_unsupported_o, 4'h4, "unsupported");
        row_double_i[1] = 0;
        for (k = 0; k < 280; k = k + 1) step(2'b00, 3'(k / 40));
        read_throttle_i = 64'h00ff_0000_0000_0001;
        step(2'b01, 3'h5);
        check(rd_thr, 1, "read_force");
        check(wr_thr, 0, "write_free");
        for (k = 0; k < 100; k = k + 1) step(2'b01, 3'h5);
        check(hits < 3, 1, "read_cut");
        read_throttle_i = 0;
        step(2'b01, 3'h5);
        step(2'b01, 3'h5);
        write_throttle_i = 64'h00ff_0003_0000_0002;
        for (k = 0; k < 60; k = k + 1) step(2'b10, 3'h5);
        check(seen_wr, 1, "write_counter");
        check(rd_thr, 0, "read_free");
        end_of_test;
    end
endmodule
